// file: pkg/lcc_regs.svh
// Constants for the logic cell cluster group: geometry, widths and encodings
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH

`define LCC_CELLS_PER_CLUSTER 10
`define LCC_LOCAL_REACH 30
`define LCC_LUT_INPUTS 4
`define LCC_LUT_SIZE 16
`define LCC_CLUSTERS_DEFAULT 16
`define LCC_SEL_W 5
`define LCC_SEL_EXTERNAL 5'h1f
`define LCC_MODE_W 2
`define LCC_ADDER_MASK 16'he896
`define LCC_FF_RESET 1'h0

`endif

// file: pkg/lcc_pkg.sv
// Types shared by the logic cell cluster group and its logic cell
package lcc_pkg;

    typedef enum logic [1:0] {
        LCC_MODE_NORMAL,
        LCC_MODE_ARITH,
        LCC_MODE_CARRY_TAP
    } lcc_mode_t;

    typedef struct packed {
        logic ff;
    } lcc_cell_state_t;

endpackage

// file: design/lcc_logic_cell.sv
// One logic cell: four-input lookup table, chain logic, register and two outputs
`timescale 1ns/100ps
`include "lcc_regs.svh"

module lcc_logic_cell (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic sclr_in,
    input wire logic [`LCC_LUT_INPUTS-1:0] data_in,
    input wire logic carry_in,
    input wire logic cascade_in,
    input wire logic [`LCC_LUT_SIZE-1:0] lut_mask_in,
    input wire lcc_pkg::lcc_mode_t mode_in,
    input wire logic cascade_use_in,
    input wire logic cascade_or_in,
    input wire logic sel_a_reg_in,
    input wire logic sel_b_reg_in,
    output logic lut_out,
    output logic reg_out,
    output logic out_a_out,
    output logic out_b_out,
    output logic carry_out,
    output logic cascade_out
);
    import lcc_pkg::*;

    lcc_cell_state_t st_q;
    lcc_cell_state_t st_d;
    logic [2:0] arith_idx;
    logic func;
    logic chain_in;

    always_comb begin
        // Arithmetic: low half of the mask gives the sum, high half the carry
        arith_idx = {carry_in, data_in[1:0]}; // see [RULE_06] see [RULE_10]
        carry_out = 1'b0;
        case (mode_in)
            LCC_MODE_ARITH: begin
                func = lut_mask_in[{1'b0, arith_idx}];
                carry_out = lut_mask_in[{1'b1, arith_idx}]; // see [RULE_12]
            end
            LCC_MODE_CARRY_TAP: begin
                func = carry_in; // see [RULE_12]
            end
            LCC_MODE_NORMAL: begin
                func = lut_mask_in[data_in]; // see [RULE_16]
            end
            default: begin
                func = lut_mask_in[data_in];
            end
        endcase
        // An unused cascade input is the identity of the chosen operator
        chain_in = cascade_use_in ? cascade_in : ~cascade_or_in;
        if (cascade_or_in) begin
            lut_out = ~(~func & ~chain_in); // see [RULE_13]
        end else begin
            lut_out = func & chain_in; // see [RULE_13] see [RULE_14]
        end
        cascade_out = lut_out;
        st_d = st_q;
        if (ce_in) begin
            st_d.ff = sclr_in ? `LCC_FF_RESET : lut_out; // see [RULE_11]
        end
        reg_out = st_q.ff;
        out_a_out = sel_a_reg_in ? st_q.ff : lut_out; // see [RULE_04] see [RULE_05]
        out_b_out = sel_b_reg_in ? st_q.ff : lut_out; // see [RULE_04]
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    sequence clear_req_s;
        ce_in && sclr_in;
    endsequence

    cell_sclr_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_11]
        clear_req_s |=> !reg_out)
        else $error("cell register not cleared");

    adder_sum_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_10]
        (mode_in == LCC_MODE_ARITH && lut_mask_in == `LCC_ADDER_MASK && !cascade_use_in
            && !cascade_or_in) |-> lut_out == (data_in[0] ^ data_in[1] ^ carry_in))
        else $error("adder sum wrong");

    adder_carry_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_06]
        (mode_in == LCC_MODE_ARITH && lut_mask_in == `LCC_ADDER_MASK) |->
            carry_out == ((data_in[0] & data_in[1]) | (carry_in & (data_in[0] ^ data_in[1]))))
        else $error("adder carry wrong");

    cascade_and_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_13]
        (cascade_use_in && !cascade_or_in && !cascade_in) |-> !cascade_out)
        else $error("cascade and not forced low");

    cascade_or_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_13]
        (cascade_use_in && cascade_or_in && cascade_in) |-> cascade_out)
        else $error("cascade or not forced high");

    reg_capture_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_05]
        (ce_in && !sclr_in) |=> reg_out == $past(lut_out))
        else $error("register missed lookup result");
endmodule

// file: design/lcc_cluster_group.sv
// Group of ten-cell clusters with carry and cascade chains and local routing
//
// Notes on behaviour
// [RULE_01] Each cluster holds exactly ten cells with chains, controls and local routing.
// [RULE_02] Even cells drive the left local area, odd cells the right area.
// [RULE_03] A cluster reaches thirty cells: its own and both neighbour clusters.
// [RULE_04] Each cell has two outputs, each picking lookup or register independently.
// [RULE_05] A cell may show its lookup result registered and unregistered together.
// [RULE_06] Incoming carry feeds the cell lookup and the next carry stage.
// [RULE_07] Chains run cells one to ten, continuing through every cluster of the same parity in the group.
// [RULE_08] Multi-cluster carry chains hop to the next cluster of equal parity.
// [RULE_09] Multi-cluster cascade chains hop the same way, keeping parity.
// [RULE_10] An n-bit adder uses n plus one cells; sum from operands and carry.
// [RULE_11] The arithmetic cell register is optional: bypassed, or holding an accumulator.
// [RULE_12] Carry goes straight upward; a final extra cell puts it on routing.
// [RULE_13] Cascade combines neighbouring cells by AND, or by OR through De Morgan.
// [RULE_14] Every added cascade cell widens the function by four inputs.
// [RULE_15] Cascades beyond ten cells continue through further clusters.
// [RULE_16] Each lookup is four inputs plus a dedicated carry or cascade input.
`timescale 1ns/100ps
`include "lcc_regs.svh"

module lcc_cluster_group #(
    parameter int NUM_CLUSTERS = `LCC_CLUSTERS_DEFAULT,
    parameter int CELLS = `LCC_CELLS_PER_CLUSTER,
    parameter int NCELL = NUM_CLUSTERS * CELLS
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic [NUM_CLUSTERS-1:0] cluster_ena_in,
    input wire logic [NUM_CLUSTERS-1:0] cluster_sclr_in,
    input wire logic [NCELL*`LCC_LUT_INPUTS-1:0] ext_data_in,
    input wire logic [NCELL*`LCC_LUT_INPUTS*`LCC_SEL_W-1:0] src_sel_in,
    input wire logic [NCELL*`LCC_LUT_SIZE-1:0] lut_mask_in,
    input wire logic [NCELL*`LCC_MODE_W-1:0] cell_mode_in,
    input wire logic [NCELL-1:0] cascade_use_in,
    input wire logic [NCELL-1:0] cascade_or_in,
    input wire logic [NCELL-1:0] sel_a_reg_in,
    input wire logic [NCELL-1:0] sel_b_reg_in,
    input wire logic [1:0] chain_carry_in,
    input wire logic [1:0] chain_cascade_in,
    output logic [NCELL-1:0] cell_a_out,
    output logic [NCELL-1:0] cell_b_out,
    output logic [1:0] chain_carry_out,
    output logic [1:0] chain_cascade_out
);
    import lcc_pkg::*;

    localparam int HALF = CELLS / 2;
    localparam int LAST_EVEN = ((NUM_CLUSTERS - 1) % 2 == 0) ? NUM_CLUSTERS - 1 : NUM_CLUSTERS - 2;
    localparam int LAST_ODD = ((NUM_CLUSTERS - 1) % 2 == 1) ? NUM_CLUSTERS - 1 : NUM_CLUSTERS - 2;

    typedef struct packed {
        logic [NCELL-1:0] out_a;
        logic [NCELL-1:0] out_b;
        logic [1:0] carry;
        logic [1:0] cascade;
    } lcc_grp_state_t;

    lcc_grp_state_t st_q;
    lcc_grp_state_t st_d;

    logic [NCELL-1:0] lut_w;
    logic [NCELL-1:0] reg_w;
    logic [NCELL-1:0] a_w;
    logic [NCELL-1:0] b_w;
    logic [NCELL-1:0] carry_w;
    logic [NCELL-1:0] casc_w;
    logic [NCELL-1:0] carry_in_w;
    logic [NCELL-1:0] casc_in_w;
    logic [NUM_CLUSTERS*HALF-1:0] left_area_w;
    logic [NUM_CLUSTERS*HALF-1:0] right_area_w;
    logic [NUM_CLUSTERS*`LCC_LOCAL_REACH-1:0] pool_w;

    // Local routing carries the registered A outputs; the pipeline stage
    // keeps feedback through the fabric free of combinational loops.
    genvar k;
    genvar s;
    genvar n;
    generate
        for (k = 0; k < NUM_CLUSTERS; k++) begin : g_area
            for (s = 0; s < HALF; s++) begin : g_side
                assign left_area_w[k*HALF+s] = st_q.out_a[k*CELLS+2*s]; // see [RULE_02]
                assign right_area_w[k*HALF+s] = st_q.out_a[k*CELLS+2*s+1]; // see [RULE_02]
            end
        end
        for (k = 0; k < NUM_CLUSTERS; k++) begin : g_pool
            // Pool order: left areas of clusters k-1, k, k+1, then right areas
            for (n = 0; n < 3; n++) begin : g_nb
                if (k - 1 + n >= 0 && k - 1 + n < NUM_CLUSTERS) begin : g_have
                    assign pool_w[k*`LCC_LOCAL_REACH+n*HALF +: HALF] =
                        left_area_w[(k-1+n)*HALF +: HALF]; // see [RULE_03]
                    assign pool_w[k*`LCC_LOCAL_REACH+3*HALF+n*HALF +: HALF] =
                        right_area_w[(k-1+n)*HALF +: HALF]; // see [RULE_03]
                end else begin : g_edge
                    assign pool_w[k*`LCC_LOCAL_REACH+n*HALF +: HALF] = '0;
                    assign pool_w[k*`LCC_LOCAL_REACH+3*HALF+n*HALF +: HALF] = '0;
                end
            end
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < NCELL; i++) begin : g_cell
            localparam int CL = i / CELLS;
            localparam int POS = i % CELLS;
            logic [`LCC_LUT_INPUTS-1:0] din;
            logic [`LCC_LOCAL_REACH-1:0] pool;

            assign pool = pool_w[CL*`LCC_LOCAL_REACH +: `LCC_LOCAL_REACH];

            always_comb begin
                for (int p = 0; p < `LCC_LUT_INPUTS; p++) begin
                    logic [`LCC_SEL_W-1:0] sel;
                    sel = src_sel_in[(i*`LCC_LUT_INPUTS+p)*`LCC_SEL_W +: `LCC_SEL_W];
                    if (sel == `LCC_SEL_EXTERNAL) begin
                        din[p] = ext_data_in[i*`LCC_LUT_INPUTS+p];
                    end else if (32'(sel) < `LCC_LOCAL_REACH) begin
                        din[p] = pool[sel];
                    end else begin
                        din[p] = 1'b0;
                    end
                end
            end

            // Chains run cell one to ten, then jump to the cluster two above
            if (POS > 0) begin : g_mid
                assign carry_in_w[i] = carry_w[i-1]; // see [RULE_07]
                assign casc_in_w[i] = casc_w[i-1]; // see [RULE_07]
            end else if (CL >= 2) begin : g_hop
                assign carry_in_w[i] = carry_w[(CL-2)*CELLS+CELLS-1]; // see [RULE_08]
                assign casc_in_w[i] = casc_w[(CL-2)*CELLS+CELLS-1]; // see [RULE_09] see [RULE_15]
            end else begin : g_head
                assign carry_in_w[i] = chain_carry_in[CL];
                assign casc_in_w[i] = chain_cascade_in[CL];
            end

            lcc_logic_cell u_cell (
                .mclk_in(mclk_in),
                .rst_b_in(rst_b_in),
                .ce_in(ce_in & cluster_ena_in[CL]), // see [RULE_01]
                .sclr_in(cluster_sclr_in[CL]),
                .data_in(din),
                .carry_in(carry_in_w[i]),
                .cascade_in(casc_in_w[i]),
                .lut_mask_in(lut_mask_in[i*`LCC_LUT_SIZE +: `LCC_LUT_SIZE]),
                .mode_in(lcc_mode_t'(cell_mode_in[i*`LCC_MODE_W +: `LCC_MODE_W])),
                .cascade_use_in(cascade_use_in[i]),
                .cascade_or_in(cascade_or_in[i]),
                .sel_a_reg_in(sel_a_reg_in[i]),
                .sel_b_reg_in(sel_b_reg_in[i]),
                .lut_out(lut_w[i]),
                .reg_out(reg_w[i]),
                .out_a_out(a_w[i]),
                .out_b_out(b_w[i]),
                .carry_out(carry_w[i]),
                .cascade_out(casc_w[i])
            );
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        if (ce_in) begin
            st_d.out_a = a_w; // see [RULE_04]
            st_d.out_b = b_w; // see [RULE_04]
            st_d.carry = {carry_w[LAST_ODD*CELLS+CELLS-1], carry_w[LAST_EVEN*CELLS+CELLS-1]};
            st_d.cascade = {casc_w[LAST_ODD*CELLS+CELLS-1], casc_w[LAST_EVEN*CELLS+CELLS-1]};
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cell_a_out = st_q.out_a;
    assign cell_b_out = st_q.out_b;
    assign chain_carry_out = st_q.carry;
    assign chain_cascade_out = st_q.cascade;

    sequence frozen_s;
        !ce_in;
    endsequence

    sequence sampled_s;
        ce_in ##1 1'b1;
    endsequence

    group_freeze_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_01]
        frozen_s |=> $stable(cell_a_out) && $stable(cell_b_out) && $stable(chain_carry_out))
        else $error("outputs moved while clock enable low");

    out_select_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_04]
        ce_in |=> cell_b_out[0] == ($past(sel_b_reg_in[0]) ? $past(reg_w[0]) : $past(lut_w[0])))
        else $error("output B select wrong");

    carry_even_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_08]
        sampled_s |-> chain_carry_out[0] == $past(carry_w[LAST_EVEN*CELLS+CELLS-1]))
        else $error("even carry lane output wrong");

    cascade_odd_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_09]
        sampled_s |-> chain_cascade_out[1] == $past(casc_w[LAST_ODD*CELLS+CELLS-1]))
        else $error("odd cascade lane output wrong");

    carry_ripple_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_06]
        (cell_mode_in[`LCC_MODE_W +: `LCC_MODE_W] == 2'(LCC_MODE_CARRY_TAP)
            && !cascade_or_in[1] && !cascade_use_in[1]) |-> lut_w[1] == carry_w[0])
        else $error("carry tap cell does not show carry");

    carry_head_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_08]
        (cell_mode_in[`LCC_MODE_W-1:0] == 2'(LCC_MODE_CARRY_TAP)
            && !cascade_or_in[0] && !cascade_use_in[0]) |-> lut_w[0] == chain_carry_in[0])
        else $error("chain head carry lost");

    // The hop from cluster zero to cluster two is the first one the even chain takes
    generate
        if (NUM_CLUSTERS >= 3) begin : g_hop_chk
            carry_hop_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_08]
                (cell_mode_in[2*CELLS*`LCC_MODE_W +: `LCC_MODE_W] == 2'(LCC_MODE_CARRY_TAP)
                    && !cascade_or_in[2*CELLS] && !cascade_use_in[2*CELLS])
                    |-> lut_w[2*CELLS] == carry_w[CELLS-1])
                else $error("carry hop to cluster two lost");

            cascade_hop_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // see [RULE_09]
                (cascade_use_in[2*CELLS] && !cascade_or_in[2*CELLS] && !casc_w[CELLS-1])
                    |-> !casc_w[2*CELLS])
                else $error("cascade hop to cluster two lost");
        end
    endgenerate
endmodule

// file: tb/tb.sv
// Self-checking bench for the logic cell cluster group
`timescale 1ns/100ps
`include "lcc_regs.svh"

module tb;
    localparam int NCL = 4;
    localparam int NC = NCL * `LCC_CELLS_PER_CLUSTER;
    localparam logic [19:0] S_AB = {5'h1e, 5'h1e, `LCC_SEL_EXTERNAL, `LCC_SEL_EXTERNAL};
    localparam logic [19:0] S_D0 = {5'h1e, 5'h1e, 5'h1e, `LCC_SEL_EXTERNAL};
    localparam logic [19:0] S_ALL = {4{`LCC_SEL_EXTERNAL}};
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic ce = 1'b1, ce_d = 1'b1;
    logic [NCL-1:0] ena = '1, ena_d = '1, sclr = '0, sclr_d = '0;
    logic [NC*4-1:0] ext = '0, ext_d = '0;
    logic [NC*20-1:0] src = '0, src_d = '0;
    logic [NC*16-1:0] msk = '0, msk_d = '0;
    logic [NC*2-1:0] mode = '0, mode_d = '0;
    logic [NC-1:0] cu = '0, cu_d = '0, co = '0, co_d = '0;
    logic [NC-1:0] sa = '0, sa_d = '0, sb = '0, sb_d = '0;
    logic [1:0] cyin = '0, cyin_d = '0, csin = '0, csin_d = '0;
    logic [NC-1:0] a_o, b_o;
    logic [1:0] cy_o, cs_o;
    int n_fail = 0;
    int samples_checked = 0;

    always #12.5 mclk_in = ~mclk_in;

    // Shadow settings are edited between edges and land together on the next rising edge
    always @(posedge mclk_in) begin
        {ce, ena, sclr, ext, src, msk} <= {ce_d, ena_d, sclr_d, ext_d, src_d, msk_d};
        {mode, cu, co, sa, sb, cyin, csin} <= {mode_d, cu_d, co_d, sa_d, sb_d, cyin_d, csin_d};
    end

    lcc_cluster_group #(.NUM_CLUSTERS(NCL)) u_dut (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce), .cluster_ena_in(ena),
        .cluster_sclr_in(sclr), .ext_data_in(ext), .src_sel_in(src), .lut_mask_in(msk),
        .cell_mode_in(mode), .cascade_use_in(cu), .cascade_or_in(co), .sel_a_reg_in(sa),
        .sel_b_reg_in(sb), .chain_carry_in(cyin), .chain_cascade_in(csin),
        .cell_a_out(a_o), .cell_b_out(b_o), .chain_carry_out(cy_o),
        .chain_cascade_out(cs_o)
    );

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    function automatic void setc(int i, logic [1:0] md, logic [15:0] m, logic [19:0] s,
                                 logic a, logic b, logic u, logic o);
        mode_d[i*2 +: 2] = md;
        msk_d[i*16 +: 16] = m;
        src_d[i*20 +: 20] = s;
        {sa_d[i], sb_d[i], cu_d[i], co_d[i]} = {a, b, u, o};
    endfunction

    function automatic void cfg_all(logic [15:0] m, logic [19:0] s);
        for (int i = 0; i < NC; i++) begin
            setc(i, 2'h0, m, s, 1'b0, 1'b0, 1'b0, 1'b0);
        end
    endfunction

    // Ten-bit adder in cluster 0, carry tapped two clusters up; cluster 1 taps its own head
    task automatic t_adder();
        logic [9:0] va [5] = '{10'h000, 10'h3ff, 10'h3ff, 10'h200, 10'h155};
        logic [9:0] vb [5] = '{10'h000, 10'h001, 10'h3ff, 10'h200, 10'h000};
        logic vc [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        logic [10:0] sum;
        logic [NC*4-1:0] keep;
        cfg_all(16'h0000, S_AB);
        for (int i = 0; i < 10; i++) begin
            setc(i, 2'h1, `LCC_ADDER_MASK, S_AB, 1'b0, 1'b1, 1'b0, 1'b0);
        end
        setc(10, 2'h2, 16'h0000, S_AB, 1'b0, 1'b0, 1'b0, 1'b0);
        setc(20, 2'h2, 16'h0000, S_AB, 1'b0, 1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 5; k++) begin
            sum = va[k] + vb[k] + vc[k];
            ext_d = '0;
            for (int i = 0; i < 10; i++) begin
                ext_d[i*4] = va[k][i];
                ext_d[i*4+1] = vb[k][i];
            end
            cyin_d = {~sum[10], vc[k]};
            cyc(2);
            chk("sum_lut", {6'h00, sum[9:0]}, {6'h00, a_o[9:0]});
            chk("carry_tap", {15'h0000, sum[10]}, {15'h0000, a_o[20]});
            chk("odd_tap", {15'h0000, ~sum[10]}, {15'h0000, a_o[10]});
            chk("carry_lanes", 16'h0000, {14'h0000, cy_o});
            cyc(1);
            chk("sum_reg", {6'h00, sum[9:0]}, {6'h00, b_o[9:0]});
            chk("sum_both", {6'h00, sum[9:0]}, {6'h00, a_o[9:0]});
        end
        // Frozen clock enable must hold both paths although the operands vanish
        keep = ext_d;
        ce_d = 1'b0;
        ext_d = '0;
        cyc(3);
        chk("freeze_a", 16'h0156, {6'h00, a_o[9:0]});
        chk("freeze_b", 16'h0156, {6'h00, b_o[9:0]});
        ce_d = 1'b1;
        sclr_d[0] = 1'b1;
        ext_d = keep;
        cyc(3);
        chk("sclr_a", 16'h0156, {6'h00, a_o[9:0]});
        chk("sclr_b", 16'h0000, {6'h00, b_o[9:0]});
        sclr_d[0] = 1'b0;
        // Cluster enable low must keep the cleared registers from recapturing
        ena_d[0] = 1'b0;
        cyc(3);
        chk("ena_hold", 16'h0000, {6'h00, b_o[9:0]});
        ena_d[0] = 1'b1;
        cyc(3);
        chk("ena_run", 16'h0156, {6'h00, b_o[9:0]});
        $display("adder test done");
    endtask

    task automatic ccheck(input logic exp, input logic exp0);
        cyc(2);
        chk("casc_odd", {15'h0000, exp}, {15'h0000, cs_o[1]});
        chk("casc_cell", {15'h0000, exp}, {15'h0000, a_o[39]});
        chk("casc_even", {15'h0000, exp0}, {15'h0000, cs_o[0]});
    endtask

    // Odd lane: clusters 1 and 3 chained into one 80-input function
    task automatic t_cascade();
        cfg_all(16'hffff, S_ALL);
        for (int i = 0; i < NC; i++) begin
            cu_d[i] = 1'b1;
            if ((i / 10) % 2 == 1) begin
                msk_d[i*16 +: 16] = 16'h8000;
            end
        end
        ext_d = '1;
        csin_d = 2'b10;
        ccheck(1'b1, 1'b0);
        ext_d[39*4+3] = 1'b0;
        ccheck(1'b0, 1'b0);
        ext_d = '1;
        ext_d[10*4] = 1'b0;
        ccheck(1'b0, 1'b0);
        ext_d = '1;
        csin_d = 2'b01;
        ccheck(1'b0, 1'b1);
        for (int i = 10; i < NC; i++) begin
            if ((i / 10) % 2 == 1) begin
                msk_d[i*16 +: 16] = 16'hfffe;
                co_d[i] = 1'b1;
            end
        end
        csin_d = 2'b00;
        ext_d = '0;
        ccheck(1'b0, 1'b0);
        ext_d[35*4+2] = 1'b1;
        ccheck(1'b1, 1'b0);
        $display("cascade test done");
    endtask

    // Cell 15 reads every pool slot of its cluster and both neighbours except the slot carrying its own output
    task automatic t_route();
        int b;
        int idx;
        cfg_all(16'haaaa, S_D0);
        // Mode code three must behave as a normal cell
        mode_d[15*2 +: 2] = 2'h3;
        for (int p = 0; p < 30; p++) begin
            b = (p < 15) ? p : p - 15;
            idx = (b / 5) * 10 + 2 * (b % 5) + ((p < 15) ? 0 : 1);
            if (idx != 15) begin
                src_d[15*20 +: 5] = p[4:0];
                ext_d = '0;
                ext_d[idx*4] = 1'b1;
                cyc(4);
                chk("pool_hit", 16'h0001, {15'h0000, a_o[15]});
                ext_d = '0;
                cyc(4);
                chk("pool_idle", 16'h0000, {15'h0000, a_o[15]});
            end
        end
        $display("routing test done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Roughly 280 cycles of tests; a hang is cut off well beyond that
    initial begin
        repeat (5000) @(posedge mclk_in);
        n_fail++;
        $display("ERROR watchdog expected done seen timeout");
        summarize();
    end

    initial begin
        repeat (5) @(posedge mclk_in);
        @(negedge mclk_in);
        chk("reset_out", 16'h0000, {a_o[5:0], b_o[5:0], cy_o, cs_o});
        @(posedge mclk_in);
        rst_b_in <= 1'b1;
        cyc(1);
        chk("release_out", 16'h0000, {a_o[5:0], b_o[5:0], cy_o, cs_o});
        $display("reset test done");
        t_adder();
        t_cascade();
        t_route();
        summarize();
    end
endmodule
